// ===== msd_chk.sv
// port checker for the memory space decoder
`timescale 1ns/10ps
module msd_chk #(
  parameter ROM_SIZE = 1,
  parameter SYNC_PROG = 1,
  parameter WS_W = 3
) (
  // clock and requests
  input wire clk,
  input wire resetn,
  input wire prg_req,
  input wire [23:0] prg_addr,
  input wire xd_req,
  input wire [WS_W-1:0] xd_wait_states,
  input wire dpx_load,
  input wire [7:0] dpx_wdata,
  input wire dir_req,
  input wire dir_wr,
  input wire dir_indirect,
  input wire [7:0] dir_addr,
  input wire core_sfr_hit,
  // answers
  input wire core_hold,
  input wire acc_done,
  input wire dir_valid,
  input wire user_special_registers_oe,
  input wire [7:0] data_pointer_extension,
  input wire prg_rom_sel,
  input wire prg_ram_sel,
  input wire [23:0] ext_addr,
  input wire ext_data_oe_n,
  input wire ext_prg_rd,
  input wire ext_ram_rd,
  input wire ext_ram_wr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0] cnt;
  logic [WS_W-1:0] ws;
  logic isx;
  wire take = !core_hold && (prg_req || xd_req);
  wire ext_on = ext_prg_rd || ext_ram_rd || ext_ram_wr;
  // =========================================================
  // access length counter, restarted at every take
  always @(posedge clk)
  begin
    if (!resetn)
      cnt <= 8'h0;
    else if (take)
      cnt <= 8'h1;
    else if (core_hold)
      cnt <= cnt + 8'h1;
  end
  // wait setting and kind latched at take
  always @(posedge clk)
  begin
    if (take)
      ws <= xd_wait_states;
    if (!resetn)
      isx <= 1'b0;
    else if (take)
      isx <= xd_req && !prg_req;
  end
  // =========================================================
  sequence rom_rd;
    take && prg_req && prg_addr < ROM_SIZE && SYNC_PROG == 1;
  endsequence
  sequence rom_ans;
    prg_rom_sel [*2] ##1 acc_done;
  endsequence
  take_hold_a: assert property (take |=> core_hold)
    else $error("no hold after take");
  rom_lat_a: assert property (rom_rd |=> rom_ans)
    else $error("rom read timing wrong");
  ext_len_a: assert property (acc_done && isx |-> cnt >= ws + 3)
    else $error("xdata access too short");
  int_excl_a: assert property (prg_rom_sel || prg_ram_sel |-> !ext_on)
    else $error("external strobe on internal access");
  dpx_load_a: assert property (dpx_load |=>
    data_pointer_extension == $past(dpx_wdata))
    else $error("extension not loaded");
  xaddr_top_a: assert property (ext_ram_rd |->
    ext_addr[23:16] == data_pointer_extension)
    else $error("xdata top byte wrong");
  sfr_block_a: assert property (dir_req && !dir_indirect && dir_addr[7]
    && core_sfr_hit |=> !user_special_registers_oe)
    else $error("user register hit on core address");
  dir_lat_a: assert property (dir_req && !dir_wr
    && (dir_indirect || !dir_addr[7]) |-> ##3 dir_valid)
    else $error("data memory read latency wrong");
  rd_bus_free_a: assert property (ext_prg_rd || ext_ram_rd
    |-> ext_data_oe_n)
    else $error("data bus driven during read");
endmodule // msd_chk

bind msd_decoder msd_chk #(.ROM_SIZE(ROM_SIZE), .SYNC_PROG(SYNC_PROG),
  .WS_W(WS_W)) chk (.*);

// ===== msd_decoder.v
// memory space decoder: program, external data, internal data and sfr
`timescale 1ns/10ps

// How it works
// - program addresses below the rom size select the internal program rom
// - program addresses from 64 kB minus ram size to FFFFh select program ram
// - all other program addresses up to 16 MB go to external program memory
// - rom and ram sizes are build parameters from zero to 64 kB
// - a build parameter picks synchronous or asynchronous program memory timing
// - 256 bytes of internal data memory as single-port synchronous ram
// - external data reaches 16 MB; extension register gives the top byte
// - direct addresses 80h-FFh not held by core sfrs go to user sfrs
// - while a slow memory holds the access, the core is told to hold
// - external program and external data cycles stretch by programmable wait states
`include "msd_map.vh"

module msd_decoder #(
  parameter ROM_SIZE = `MSD_ROM_SIZE_DEF,
  parameter RAM_SIZE = `MSD_RAM_SIZE_DEF,
  parameter SYNC_PROG = `MSD_SYNC_PROG_DEF,
  parameter WS_W = `MSD_WS_W
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // program access from the core
  input wire prg_req,
  input wire prg_wr,
  input wire [23:0] prg_addr,
  input wire [7:0] prg_wdata,
  // external data access from the core
  input wire xd_req,
  input wire xd_wr,
  input wire [15:0] xd_ptr,
  input wire [7:0] xd_wdata,
  input wire dpx_load,
  input wire [7:0] dpx_wdata,
  // wait-state settings from the core
  input wire [WS_W-1:0] prg_wait_states,
  input wire [WS_W-1:0] xd_wait_states,
  // answer to the core
  output wire core_hold,
  output reg acc_done,
  output reg [7:0] acc_rdata,
  output reg [7:0] data_pointer_extension,
  // internal program memory
  output reg [15:0] prg_mem_addr,
  output reg [7:0] prg_mem_wdata,
  output reg prg_rom_sel,
  output reg prg_ram_sel,
  output reg prg_ram_wr,
  input wire [7:0] prg_rom_data,
  input wire [7:0] prg_ram_data,
  // external memories
  output reg [23:0] ext_addr,
  output reg [7:0] ext_wdata,
  output reg ext_data_oe_n,
  input wire [7:0] ext_rdata,
  output reg ext_prg_rd,
  output reg ext_prg_wr,
  output reg ext_ram_rd,
  output reg ext_ram_wr,
  input wire ext_ready,
  // direct and indirect internal data access
  input wire dir_req,
  input wire dir_wr,
  input wire dir_indirect,
  input wire [7:0] dir_addr,
  input wire [7:0] dir_wdata,
  input wire core_sfr_hit,
  output reg dir_valid,
  output reg [7:0] dir_rdata,
  // internal data memory
  output reg [7:0] int_ram_addr,
  output reg [7:0] int_ram_wdata,
  output reg int_ram_oe,
  output reg int_ram_we,
  input wire [7:0] int_ram_rdata,
  // user special registers
  output reg [6:0] user_special_registers_addr,
  output reg [7:0] user_special_registers_wdata,
  output reg user_special_registers_oe,
  output reg user_special_registers_we,
  input wire [7:0] user_special_registers_rdata
);

  // region limits as 24-bit addresses, worked out at build time
  localparam integer RAM_BASE_I = `MSD_PAGE_TOP_INT - RAM_SIZE;
  localparam [23:0] ROM_LIM = ROM_SIZE[23:0];
  localparam [23:0] RAM_BASE = RAM_BASE_I[23:0];

  reg [2:0] state;
  reg is_prg;
  reg is_wr;
  reg rd_rom;
  reg rdy_meta;
  reg rdy_sync;
  reg tmr_start;
  reg [WS_W-1:0] tmr_count;
  reg dir_pend;
  reg dir_from_sfr;
  reg dir_pend2;
  reg dir_sfr2;
  wire tmr_done;
  wire hit_rom;
  wire hit_ram;

  // ==========================================================
  // program address decode
  assign hit_rom = prg_addr < ROM_LIM;
  assign hit_ram = (prg_addr < `MSD_PAGE_TOP) & (prg_addr >= RAM_BASE);

  // the core stalls for the whole access, internal or external
  assign core_hold = (state != `MSD_ST_IDLE);

  // ==========================================================
  // ready comes from an off-chip pin, so it is synchronised first
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      rdy_meta <= 1'b0;
      rdy_sync <= 1'b0;
    end
    else
    begin
      rdy_meta <= ext_ready;
      rdy_sync <= rdy_meta;
    end
  end

  msd_wait_timer #(
    .WS_W(WS_W)
  ) u_wait (
    .clk(clk),
    .resetn(resetn),
    .start(tmr_start),
    .count(tmr_count),
    .ready_s(rdy_sync),
    .done(tmr_done)
  );

  // ==========================================================
  // extension register: upper address byte of external data
  always @(posedge clk)
  begin
    if (!resetn)
      data_pointer_extension <= 8'h00;
    else if (dpx_load)
      data_pointer_extension <= dpx_wdata;
  end

  // ==========================================================
  // access sequencer for program and external data; a request is
  // taken only in idle, program wins when both arrive together
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      state <= `MSD_ST_IDLE;
      is_prg <= 1'b0;
      is_wr <= 1'b0;
      rd_rom <= 1'b0;
      acc_done <= 1'b0;
      acc_rdata <= 8'h00;
      prg_mem_addr <= 16'h0000;
      prg_mem_wdata <= 8'h00;
      prg_rom_sel <= 1'b0;
      prg_ram_sel <= 1'b0;
      prg_ram_wr <= 1'b0;
      ext_addr <= 24'h000000;
      ext_wdata <= 8'h00;
      ext_data_oe_n <= 1'b1;
      ext_prg_rd <= 1'b0;
      ext_prg_wr <= 1'b0;
      ext_ram_rd <= 1'b0;
      ext_ram_wr <= 1'b0;
      tmr_start <= 1'b0;
      tmr_count <= {WS_W{1'b0}};
    end
    else
    begin
      acc_done <= 1'b0;
      tmr_start <= 1'b0;
      prg_ram_wr <= 1'b0;
      case (state)
        `MSD_ST_IDLE:
        begin
          is_prg <= prg_req;
          if (prg_req)
            is_wr <= prg_wr;
          else
            is_wr <= xd_wr;
          if (prg_req && (hit_rom || hit_ram))
          begin
            // internal region: no external strobe is raised
            prg_mem_addr <= prg_addr[15:0];
            prg_mem_wdata <= prg_wdata;
            rd_rom <= hit_rom;
            prg_rom_sel <= hit_rom;
            prg_ram_sel <= ~hit_rom;
            prg_ram_wr <= prg_wr & ~hit_rom;
            state <= `MSD_ST_INT;
          end
          else if (prg_req)
          begin
            ext_addr <= prg_addr;
            ext_wdata <= prg_wdata;
            ext_data_oe_n <= ~prg_wr;
            ext_prg_rd <= ~prg_wr;
            ext_prg_wr <= prg_wr;
            tmr_count <= prg_wait_states;
            tmr_start <= 1'b1;
            state <= `MSD_ST_EXT;
          end
          else if (xd_req)
          begin
            ext_addr <= {data_pointer_extension, xd_ptr};
            ext_wdata <= xd_wdata;
            ext_data_oe_n <= ~xd_wr;
            ext_ram_rd <= ~xd_wr;
            ext_ram_wr <= xd_wr;
            tmr_count <= xd_wait_states;
            tmr_start <= 1'b1;
            state <= `MSD_ST_EXT;
          end
        end
        `MSD_ST_INT:
        begin
          // synchronous memory returns data one clock after the address
          if (SYNC_PROG != 0)
            state <= `MSD_ST_INT2;
          else
          begin
            acc_rdata <= rd_rom ? prg_rom_data : prg_ram_data;
            acc_done <= 1'b1;
            prg_rom_sel <= 1'b0;
            prg_ram_sel <= 1'b0;
            state <= `MSD_ST_IDLE;
          end
        end
        `MSD_ST_INT2:
        begin
          acc_rdata <= rd_rom ? prg_rom_data : prg_ram_data;
          acc_done <= 1'b1;
          prg_rom_sel <= 1'b0;
          prg_ram_sel <= 1'b0;
          state <= `MSD_ST_IDLE;
        end
        `MSD_ST_EXT:
        begin
          // the strobe stands until wait states and ready are both met
          if (tmr_done && !tmr_start)
          begin
            if (!is_wr)
              acc_rdata <= ext_rdata;
            acc_done <= 1'b1;
            ext_data_oe_n <= 1'b1;
            ext_prg_rd <= 1'b0;
            ext_prg_wr <= 1'b0;
            ext_ram_rd <= 1'b0;
            ext_ram_wr <= 1'b0;
            state <= `MSD_ST_IDLE;
          end
        end
        default:
          state <= `MSD_ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // direct/indirect data space: indirect and low direct hit the ram,
  // high direct hits a user register unless the core owns that address
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      int_ram_addr <= 8'h00;
      int_ram_wdata <= 8'h00;
      int_ram_oe <= 1'b0;
      int_ram_we <= 1'b0;
      user_special_registers_addr <= 7'h00;
      user_special_registers_wdata <= 8'h00;
      user_special_registers_oe <= 1'b0;
      user_special_registers_we <= 1'b0;
      dir_pend <= 1'b0;
      dir_from_sfr <= 1'b0;
      dir_pend2 <= 1'b0;
      dir_sfr2 <= 1'b0;
      dir_valid <= 1'b0;
      dir_rdata <= 8'h00;
    end
    else
    begin
      int_ram_oe <= 1'b0;
      int_ram_we <= 1'b0;
      user_special_registers_oe <= 1'b0;
      user_special_registers_we <= 1'b0;
      dir_pend <= 1'b0;
      dir_valid <= 1'b0;
      dir_pend2 <= dir_pend;
      dir_sfr2 <= dir_from_sfr;
      if (dir_req && (dir_indirect || dir_addr < `MSD_SFR_BASE))
      begin
        int_ram_addr <= dir_addr;
        int_ram_wdata <= dir_wdata;
        int_ram_oe <= ~dir_wr;
        int_ram_we <= dir_wr;
        dir_pend <= ~dir_wr;
        dir_from_sfr <= 1'b0;
      end
      else if (dir_req && !core_sfr_hit)
      begin
        user_special_registers_addr <= dir_addr[6:0];
        user_special_registers_wdata <= dir_wdata;
        user_special_registers_oe <= ~dir_wr;
        user_special_registers_we <= dir_wr;
        dir_pend <= ~dir_wr;
        dir_from_sfr <= 1'b1;
      end
      // memory latches the enable one edge later, so data is taken
      // on the edge after that; a second stage keeps the source
      if (dir_pend2)
      begin
        dir_valid <= 1'b1;
        dir_rdata <= dir_sfr2 ? user_special_registers_rdata :
                     int_ram_rdata;
      end
    end
  end

endmodule // msd_decoder

// ===== msd_map.vh
// address map, field limits, state codes and defaults for the decoder
`ifndef MSD_MAP_VH
`define MSD_MAP_VH

// ==========================================================
// address space
`define MSD_ADDR_W 24
`define MSD_PAGE_TOP 24'h010000
`define MSD_PAGE_TOP_INT 65536
`define MSD_SFR_BASE 8'h80

// ==========================================================
// build-time defaults
`define MSD_ROM_SIZE_DEF 65536
`define MSD_RAM_SIZE_DEF 0
`define MSD_SYNC_PROG_DEF 1
`define MSD_WS_W 3

// ==========================================================
// access sequencer states
`define MSD_ST_IDLE 3'h0
`define MSD_ST_INT 3'h1
`define MSD_ST_INT2 3'h2
`define MSD_ST_EXT 3'h3

`endif

// ===== msd_mem.sv
// behavioural memories on the far side of the decoder
`timescale 1ns/10ps
module msd_mem (
  // clock and stall control
  input wire clk,
  input wire stall,
  // program memories
  input wire [15:0] pa,
  input wire rom_sel,
  input wire ram_sel,
  output logic [7:0] rom_q,
  output logic [7:0] ram_q,
  // external memory
  input wire [23:0] xa,
  input wire xrd,
  output wire [7:0] xq,
  output wire xready,
  // data memory and user registers
  input wire [7:0] da,
  input wire doe,
  input wire [6:0] sa,
  input wire soe,
  output logic [7:0] dq,
  output logic [7:0] sq
);
  // unselected lines invert so a stale byte never passes
  assign xq = (xa[23:16] ^ xa[7:0] ^ 8'h3c) ^ {8{!xrd}};
  assign xready = !stall;
  // synchronous reads, data one clock after select
  always @(posedge clk)
  begin
    rom_q <= rom_sel ? pa[7:0] ^ 8'h5a : ~rom_q;
    ram_q <= ram_sel ? pa[7:0] ^ 8'ha5 : ~ram_q;
    dq <= doe ? da ^ 8'h11 : ~dq;
    sq <= soe ? {1'b1, sa} ^ 8'h22 : ~sq;
  end
endmodule // msd_mem

// ===== msd_wait_timer.v
// wait-state counter that stretches one external access
`timescale 1ns/10ps

module msd_wait_timer #(
  parameter WS_W = 3
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // control
  input wire start,
  input wire [WS_W-1:0] count,
  input wire ready_s,
  // result
  output wire done
);

  reg busy;
  reg [WS_W-1:0] remain;

  // ==========================================================
  // countdown, then wait on the memory's ready
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      busy <= 1'b0;
      remain <= {WS_W{1'b0}};
    end
    else if (start)
    begin
      busy <= 1'b1;
      remain <= count;
    end
    else if (busy)
    begin
      if (remain != {WS_W{1'b0}})
        remain <= remain - {{(WS_W-1){1'b0}}, 1'b1};
      else if (ready_s)
        busy <= 1'b0;
    end
  end

  // low ready extends the access after the programmed states run out
  assign done = busy & (remain == {WS_W{1'b0}}) & ready_s;

endmodule // msd_wait_timer

// ===== tb.sv
// self-checking bench for the memory space decoder
`timescale 1ns/10ps
module tb;
  localparam ROM = 4096;
  localparam RAM = 4096;
  logic clk = 0;
  logic resetn = 0;
  logic prg_req = 0, xd_req = 0, dpx_load = 0, dir_req = 0, stall = 0;
  logic prg_wr = 0, xd_wr = 0, dir_wr = 0, dir_indirect = 0;
  logic core_sfr_hit = 0;
  logic [23:0] prg_addr = 0, a;
  logic [15:0] xd_ptr = 0;
  logic [7:0] prg_wdata = 0, xd_wdata = 0, dpx_wdata = 0;
  logic [7:0] dir_addr = 0, dir_wdata = 0;
  logic [2:0] prg_wait_states = 0, xd_wait_states = 0;
  logic [31:0] r;
  logic [3:0] seen = 0;
  logic [23:0] ba[8] = '{24'h0, 24'hfff, 24'h1000, 24'hefff,
    24'hf000, 24'hffff, 24'h10000, 24'hffffff};
  logic [11:0] q[$], dq[$];
  integer seed = 84, num_errors = 0, num_checks = 0, cyc = 0, i;
  wire core_hold, acc_done, prg_rom_sel, prg_ram_sel, ext_prg_rd;
  wire ext_ram_rd, ext_ready, dir_valid, int_ram_oe;
  wire user_special_registers_oe;
  wire [7:0] acc_rdata, data_pointer_extension, dir_rdata, int_ram_addr;
  wire [7:0] prg_rom_data, prg_ram_data, ext_rdata, int_ram_rdata;
  wire [7:0] user_special_registers_rdata;
  wire [6:0] user_special_registers_addr;
  wire [15:0] prg_mem_addr;
  wire [23:0] ext_addr;
  // =========================================================
  // design and far-side memories
  msd_decoder #(.ROM_SIZE(ROM), .RAM_SIZE(RAM)) uut (.prg_mem_wdata(),
    .prg_ram_wr(), .ext_wdata(), .ext_data_oe_n(), .ext_prg_wr(),
    .ext_ram_wr(), .int_ram_wdata(), .int_ram_we(),
    .user_special_registers_wdata(), .user_special_registers_we(), .*);
  msd_mem mem (.clk(clk), .stall(stall), .pa(prg_mem_addr),
    .rom_sel(prg_rom_sel), .ram_sel(prg_ram_sel), .rom_q(prg_rom_data),
    .ram_q(prg_ram_data), .xa(ext_addr), .xrd(ext_prg_rd | ext_ram_rd),
    .xq(ext_rdata), .xready(ext_ready), .da(int_ram_addr),
    .doe(int_ram_oe), .sa(user_special_registers_addr),
    .soe(user_special_registers_oe), .dq(int_ram_rdata),
    .sq(user_special_registers_rdata));
  always #2.5 clk = ~clk;
  // =========================================================
  task check(input string n, input logic [11:0] s, input logic [11:0] e);
    num_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task summarize;
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // region code rom/ram/xprg and expected read byte of a program access
  function automatic logic [11:0] exp_prg(input logic [23:0] p);
    if (p < ROM)
      return {4'h8, p[7:0] ^ 8'h5a};
    if (p < 24'h10000 && p >= 24'h10000 - RAM)
      return {4'h4, p[7:0] ^ 8'ha5};
    return {4'h2, p[23:16] ^ p[7:0] ^ 8'h3c};
  endfunction
  // one access; ready stalls at random while it runs
  task acc(input bit x, input logic [23:0] p, input logic [11:0] e);
    q.push_back(e);
    prg_addr = p;
    xd_ptr = p[15:0];
    prg_wait_states = r[14:12];
    xd_wait_states = r[17:15];
    prg_req = !x;
    xd_req = x;
    @(negedge clk);
    prg_req = 0;
    xd_req = 0;
    do
    begin
      stall = ($random(seed) & 3) == 0;
      @(negedge clk);
    end while (acc_done !== 1'b1);
    stall = 0;
    @(negedge clk);
  endtask
  // =========================================================
  // result watcher, oldest note first
  always @(negedge clk)
  begin
    seen = seen | {prg_rom_sel, prg_ram_sel, ext_prg_rd, ext_ram_rd};
    if (acc_done === 1'b1)
    begin
      check("acc", {seen, acc_rdata}, q.pop_front());
      seen = 0;
    end
    if (dir_valid === 1'b1)
      check("dir", {4'h0, dir_rdata}, dq.pop_front());
  end
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      summarize;
    end
  end
  initial
  begin
    r = 0;
    repeat (10) @(negedge clk);
    resetn = 1;
    foreach (ba[k]) acc(0, ba[k], exp_prg(ba[k]));
    for (i = 0; i < 60; i++)
    begin
      r = $random(seed);
      a = r[23:0] >> (6 * (i % 3));
      if (i % 2)
      begin
        dpx_wdata = r[31:24];
        dpx_load = 1;
        @(negedge clk);
        dpx_load = 0;
        acc(1, a, {4'h1, r[31:24] ^ a[7:0] ^ 8'h3c});
      end
      else
        acc(0, a, exp_prg(a));
    end
    // back-to-back direct accesses
    for (i = 0; i < 40; i++)
    begin
      r = $random(seed);
      {dir_wr, dir_indirect, core_sfr_hit} = r[10:8];
      dir_addr = r[7:0];
      dir_wdata = r[31:24];
      dir_req = 1;
      if (!r[10] && !(r[7] && !r[9] && r[8]))
        dq.push_back({4'h0, r[7:0] ^ ((r[9] || !r[7]) ? 8'h11 : 8'h22)});
      @(negedge clk);
    end
    dir_req = 0;
    repeat (4) @(negedge clk);
    check("left", 12'(q.size() + dq.size()), 12'h0);
    summarize;
  end
endmodule // tb
